// *** common/bpoc_pkg.sv ***
// Package: offsets, field positions, reset values and types of the power override control
package bpoc_pkg;
   // Configuration space offsets (byte addresses of aligned dwords)
   localparam logic [7:0] GEN_CTRL_OFS = 8'hd4;
   localparam logic [7:0] CLK_CTRL_OFS = 8'hd8;
   localparam logic [7:0] DEV_CAP_OFS = 8'h74;

   // General control field positions
   localparam int SPR_LSB = 20;
   localparam int SPEC_OFF_BIT = 19;
   localparam int SHALLOW_LSB = 16;
   localparam int DEEP_LSB = 13;
   localparam int VC_BIT = 12;
   localparam int D3_STOP_BIT = 11;
   localparam int BEACON_BIT = 10;

   // Device capabilities field positions
   localparam int CAP_SHALLOW_LSB = 6;
   localparam int CAP_DEEP_LSB = 9;

   // Clock disable in byte 0, clock mask in byte 1 of the D8h dword
   localparam int CLK_DIS_LSB = 0;
   localparam int CLK_MASK_LSB = 8;

   // Slot power response encodings; 3'h5..3'h7 are reserved
   localparam logic [2:0] SPR_IGNORE = 3'h0;
   localparam logic [2:0] SPR_PIN = 3'h1;
   localparam logic [2:0] SPR_CLKSTOP = 3'h2;
   localparam logic [2:0] SPR_BOTH = 3'h3;
   localparam logic [2:0] SPR_UNSUP = 3'h4;

   // Values after reset
   localparam logic [2:0] SPR_RESET = 3'h0;
   localparam logic SPEC_OFF_RESET = 1'b0;
   localparam logic [2:0] SHALLOW_RESET = 3'h0;
   localparam logic [2:0] DEEP_RESET = 3'h0;
   localparam logic D3_STOP_RESET = 1'b0;
   localparam logic BEACON_RESET = 1'b0;
   localparam logic [7:0] CLK_BYTE_RESET = 8'h00;

   // Configuration access carried as one bundle
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } bpoc_cfg_req_type;

   // Sticky general control fields that the block keeps
   typedef struct packed {
      logic [2:0] spr_sel;
      logic spec_off;
      logic [2:0] shallow;
      logic [2:0] deep;
      logic d3_stop;
      logic beacon;
   } bpoc_gen_ctrl_type;

   localparam bpoc_gen_ctrl_type GEN_RESET = '{SPR_RESET, SPEC_OFF_RESET, SHALLOW_RESET,
      DEEP_RESET, D3_STOP_RESET, BEACON_RESET};

   // Incoming request kinds seen by the classifier
   typedef enum logic [2:0] {
      REQ_MEM_RD = 3'h0,
      REQ_MEM_RD_LINE = 3'h1,
      REQ_MEM_RD_MULT = 3'h2,
      REQ_CFG0 = 3'h3,
      REQ_CFG1 = 3'h4,
      REQ_SET_SLOT_PWR = 3'h5,
      REQ_MEM_WR = 3'h6,
      REQ_OTHER = 3'h7
   } bpoc_req_kind_type;

   // Wake sequencer states, one-hot
   typedef enum logic [2:0] {
      WK_IDLE = 3'b001,
      WK_SIGNAL = 3'b010,
      WK_HOLD = 3'b100
   } bpoc_wake_state_type;
endpackage

// *** rtl/bpoc_req_class.sv ***
// Request classifier: unsupported and prefetch decisions for one request
`timescale 1ns/1ps
module bpoc_req_class (
   // Request
   input wire bpoc_pkg::bpoc_req_kind_type i_kind,
   // Control
   input wire logic [2:0] i_spr_sel,
   input wire logic i_limit_short,
   input wire logic i_spec_off,
   // Decision
   output logic o_unsupported,
   output logic o_prefetch
);
   logic exempt;
   logic is_read;

   // Config requests and slot power messages always pass
   always_comb begin
      exempt = (i_kind == bpoc_pkg::REQ_CFG0) || (i_kind == bpoc_pkg::REQ_CFG1) ||
         (i_kind == bpoc_pkg::REQ_SET_SLOT_PWR);
      o_unsupported = i_limit_short && (i_spr_sel == bpoc_pkg::SPR_UNSUP) && !exempt;
      is_read = (i_kind == bpoc_pkg::REQ_MEM_RD_LINE) || (i_kind == bpoc_pkg::REQ_MEM_RD_MULT);
      // Plain reads prefetch only while speculation is on
      if (i_kind == bpoc_pkg::REQ_MEM_RD) begin
         o_prefetch = !i_spec_off && !o_unsupported;
      end else begin
         o_prefetch = is_read && !o_unsupported;
      end
   end
endmodule

// *** rtl/bpoc_clk_gate.sv ***
// Secondary clock enable generator, one enable per clock output
`timescale 1ns/1ps
module bpoc_clk_gate #(
   parameter int N_CLK = 7
) (
   // Per-output control
   input wire logic [N_CLK-1:0] i_disable,
   input wire logic [N_CLK-1:0] i_mask,
   // Conditions
   input wire logic i_stop_masked,
   input wire logic i_stop_all,
   // Enables
   output logic [N_CLK-1:0] o_enable
);
   // Each output stops on its own disable, a masked override or D3 stop
   for (genvar g = 0; g < N_CLK; g++) begin : g_clk
      assign o_enable[g] = !i_disable[g] && !(i_stop_masked && i_mask[g])
         && !i_stop_all;
   end
endmodule

// *** rtl/bpoc_top.sv ***
// Bridge power override control: sticky general control fields and their effects
`timescale 1ns/1ps

// Contract
// - Slot power response acts only while slot limit is below the required power.
// - Selection 000 ignores the slot power limit entirely.
// - Selection 001 asserts the power override pin while the limit is exceeded.
// - Selection 010 stops secondary clocks selected in the clock mask.
// - Selection 011 stops masked clocks and asserts the power override pin.
// - Selection 100 answers unsupported, except config type 0/1 and slot power messages.
// - Speculation bit 0 makes all three memory read kinds prefetchable.
// - Speculation bit 1 prefetches only read line and read multiple.
// - Shallow idle exit field 18:16 is copied to capabilities bits 8:6.
// - Deep idle exit field 15:13 is copied to capabilities bits 11:9.
// - Virtual channel structure bit 12 reads zero, structure stays disabled.
// - D3 clock stop bit 1 stops secondary clocks in D3; 0 keeps them.
// - L2 wake uses sideband wake only, plus beacon when beacon bit set.
// - Fields are sticky, cleared by link reset, global reset or power-on reset.
// - Clock mask holds one bit per secondary clock output.
module bpoc_top #(
   parameter int N_CLK = 7
) (
   // Clock and power-on reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Sticky clears
   input wire logic i_link_reset,
   input wire logic i_global_reset_pin,
   // Configuration access
   input wire bpoc_pkg::bpoc_cfg_req_type i_cfg,
   output logic [31:0] o_cfg_rdata,
   output logic o_cfg_rvalid,
   // Power state
   input wire logic i_slot_limit_short,
   input wire logic i_d3_state,
   // Requests
   input wire logic i_req_valid,
   input wire bpoc_pkg::bpoc_req_kind_type i_req_kind,
   output logic o_req_done,
   output logic o_req_unsupported,
   output logic o_req_prefetch,
   // Secondary clocks and override pin
   output logic [N_CLK-1:0] o_sec_clk_en,
   output logic o_power_limit_exceeded_pin,
   // Link wake
   input wire logic i_link_in_l2,
   input wire logic i_wake_request,
   output logic o_wake_assert,
   output logic o_beacon_assert,
   // Capability copies
   output logic [2:0] o_cap_shallow_idle_exit,
   output logic [2:0] o_cap_deep_idle_exit
);
   bpoc_pkg::bpoc_gen_ctrl_type gen_ff, nxt_gen;
   logic [N_CLK-1:0] clk_dis_ff, nxt_clk_dis;
   logic [N_CLK-1:0] clk_mask_ff, nxt_clk_mask;
   logic [31:0] rdata_ff, nxt_rdata;
   logic rvalid_ff, nxt_rvalid;
   logic sticky_clear;

   // Address match, shared by write and read decode
   function automatic logic cfg_hit(input logic [7:0] addr, input logic [7:0] ofs);
      cfg_hit = (addr[7:2] == ofs[7:2]);
   endfunction

   // General control word as seen by software; bit 12 is hardwired zero
   function automatic logic [31:0] gen_word(input bpoc_pkg::bpoc_gen_ctrl_type g);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[bpoc_pkg::SPR_LSB +: 3] = g.spr_sel;
      w[bpoc_pkg::SPEC_OFF_BIT] = g.spec_off;
      w[bpoc_pkg::SHALLOW_LSB +: 3] = g.shallow;
      w[bpoc_pkg::DEEP_LSB +: 3] = g.deep;
      w[bpoc_pkg::VC_BIT] = 1'b0;
      w[bpoc_pkg::D3_STOP_BIT] = g.d3_stop;
      w[bpoc_pkg::BEACON_BIT] = g.beacon;
      gen_word = w;
   endfunction

   // Link or global reset wipes the sticky fields; a hot reset does not
   assign sticky_clear = i_link_reset || i_global_reset_pin;

   // Sticky register writes, byte lanes honoured
   always_comb begin
      nxt_gen = gen_ff;
      nxt_clk_dis = clk_dis_ff;
      nxt_clk_mask = clk_mask_ff;
      if (sticky_clear) begin
         nxt_gen = bpoc_pkg::GEN_RESET;
         nxt_clk_dis = bpoc_pkg::CLK_BYTE_RESET[N_CLK-1:0];
         nxt_clk_mask = bpoc_pkg::CLK_BYTE_RESET[N_CLK-1:0];
      end else if (i_cfg.wr && cfg_hit(i_cfg.addr, bpoc_pkg::GEN_CTRL_OFS)) begin
         if (i_cfg.be[2]) begin
            nxt_gen.spr_sel = i_cfg.wdata[bpoc_pkg::SPR_LSB +: 3];
            nxt_gen.spec_off = i_cfg.wdata[bpoc_pkg::SPEC_OFF_BIT];
            nxt_gen.shallow = i_cfg.wdata[bpoc_pkg::SHALLOW_LSB +: 3];
         end
         if (i_cfg.be[1]) begin
            nxt_gen.deep = i_cfg.wdata[bpoc_pkg::DEEP_LSB +: 3];
            nxt_gen.d3_stop = i_cfg.wdata[bpoc_pkg::D3_STOP_BIT];
            nxt_gen.beacon = i_cfg.wdata[bpoc_pkg::BEACON_BIT];
         end
      end else if (i_cfg.wr && cfg_hit(i_cfg.addr, bpoc_pkg::CLK_CTRL_OFS)) begin
         if (i_cfg.be[0]) begin
            nxt_clk_dis = i_cfg.wdata[bpoc_pkg::CLK_DIS_LSB +: N_CLK];
         end
         if (i_cfg.be[1]) begin
            nxt_clk_mask = i_cfg.wdata[bpoc_pkg::CLK_MASK_LSB +: N_CLK];
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         gen_ff <= bpoc_pkg::GEN_RESET;
         clk_dis_ff <= bpoc_pkg::CLK_BYTE_RESET[N_CLK-1:0];
         clk_mask_ff <= bpoc_pkg::CLK_BYTE_RESET[N_CLK-1:0];
      end else begin
         gen_ff <= nxt_gen;
         clk_dis_ff <= nxt_clk_dis;
         clk_mask_ff <= nxt_clk_mask;
      end
   end

   // Read answer one cycle after the strobe; unmapped dwords read zero
   always_comb begin
      nxt_rvalid = i_cfg.rd;
      nxt_rdata = 32'h0000_0000;
      if (!i_cfg.rd) begin
         nxt_rdata = 32'h0000_0000;
      end else if (cfg_hit(i_cfg.addr, bpoc_pkg::GEN_CTRL_OFS)) begin
         nxt_rdata = gen_word(gen_ff);
      end else if (cfg_hit(i_cfg.addr, bpoc_pkg::CLK_CTRL_OFS)) begin
         nxt_rdata[bpoc_pkg::CLK_DIS_LSB +: N_CLK] = clk_dis_ff;
         nxt_rdata[bpoc_pkg::CLK_MASK_LSB +: N_CLK] = clk_mask_ff;
      end else if (cfg_hit(i_cfg.addr, bpoc_pkg::DEV_CAP_OFS)) begin
         nxt_rdata[bpoc_pkg::CAP_SHALLOW_LSB +: 3] = gen_ff.shallow;
         nxt_rdata[bpoc_pkg::CAP_DEEP_LSB +: 3] = gen_ff.deep;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rdata_ff <= 32'h0000_0000;
         rvalid_ff <= 1'b0;
      end else begin
         rdata_ff <= nxt_rdata;
         rvalid_ff <= nxt_rvalid;
      end
   end

   // Override effects; reserved selections fall through as ignore
   logic pin_sel, clk_sel;
   logic nxt_pin, pin_ff;
   logic [N_CLK-1:0] gate_en, clk_en_ff;
   logic [2:0] cap_sh_ff, cap_dp_ff;

   always_comb begin
      pin_sel = (gen_ff.spr_sel == bpoc_pkg::SPR_PIN) ||
         (gen_ff.spr_sel == bpoc_pkg::SPR_BOTH);
      clk_sel = (gen_ff.spr_sel == bpoc_pkg::SPR_CLKSTOP) ||
         (gen_ff.spr_sel == bpoc_pkg::SPR_BOTH);
      nxt_pin = pin_sel && i_slot_limit_short;
   end

   bpoc_clk_gate #(
      .N_CLK(N_CLK)
   ) u_clk_gate (
      .i_disable(clk_dis_ff),
      .i_mask(clk_mask_ff),
      .i_stop_masked(clk_sel && i_slot_limit_short),
      .i_stop_all(i_d3_state && gen_ff.d3_stop),
      .o_enable(gate_en)
   );

   // Registered so the pins never glitch on a field change
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pin_ff <= 1'b0;
         clk_en_ff <= '1;
         cap_sh_ff <= bpoc_pkg::SHALLOW_RESET;
         cap_dp_ff <= bpoc_pkg::DEEP_RESET;
      end else begin
         pin_ff <= nxt_pin;
         clk_en_ff <= gate_en;
         cap_sh_ff <= gen_ff.shallow;
         cap_dp_ff <= gen_ff.deep;
      end
   end

   // Request classification
   logic cls_unsup, cls_pref;
   logic req_done_ff, req_unsup_ff, req_pref_ff;

   bpoc_req_class u_req_class (
      .i_kind(i_req_kind),
      .i_spr_sel(gen_ff.spr_sel),
      .i_limit_short(i_slot_limit_short),
      .i_spec_off(gen_ff.spec_off),
      .o_unsupported(cls_unsup),
      .o_prefetch(cls_pref)
   );

   // Decision stands for one cycle with the done pulse
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         req_done_ff <= 1'b0;
         req_unsup_ff <= 1'b0;
         req_pref_ff <= 1'b0;
      end else begin
         req_done_ff <= i_req_valid;
         req_unsup_ff <= i_req_valid && cls_unsup;
         req_pref_ff <= i_req_valid && cls_pref;
      end
   end

   // Wake sequencer: signal while in L2, then wait for the request to drop
   bpoc_pkg::bpoc_wake_state_type wk_ff, nxt_wk;
   logic wake_ff, nxt_wake, beacon_ff, nxt_beacon;

   always_comb begin
      nxt_wk = wk_ff;
      case (wk_ff)
         bpoc_pkg::WK_IDLE: begin
            if (i_link_in_l2 && i_wake_request) begin
               nxt_wk = bpoc_pkg::WK_SIGNAL;
            end
         end
         bpoc_pkg::WK_SIGNAL: begin
            if (!i_link_in_l2) begin
               nxt_wk = bpoc_pkg::WK_HOLD;
            end
         end
         bpoc_pkg::WK_HOLD: begin
            if (!i_wake_request) begin
               nxt_wk = bpoc_pkg::WK_IDLE;
            end
         end
         default: begin
            nxt_wk = bpoc_pkg::WK_IDLE;
         end
      endcase
      nxt_wake = (nxt_wk == bpoc_pkg::WK_SIGNAL);
      nxt_beacon = nxt_wake && gen_ff.beacon;
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wk_ff <= bpoc_pkg::WK_IDLE;
         wake_ff <= 1'b0;
         beacon_ff <= 1'b0;
      end else begin
         wk_ff <= nxt_wk;
         wake_ff <= nxt_wake;
         beacon_ff <= nxt_beacon;
      end
   end

   // Outputs straight from flip-flops
   assign o_cfg_rdata = rdata_ff;
   assign o_cfg_rvalid = rvalid_ff;
   assign o_req_done = req_done_ff;
   assign o_req_unsupported = req_unsup_ff;
   assign o_req_prefetch = req_pref_ff;
   assign o_sec_clk_en = clk_en_ff;
   assign o_power_limit_exceeded_pin = pin_ff;
   assign o_wake_assert = wake_ff;
   assign o_beacon_assert = beacon_ff;
   assign o_cap_shallow_idle_exit = cap_sh_ff;
   assign o_cap_deep_idle_exit = cap_dp_ff;

   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence s_wake_start;
      wk_ff == bpoc_pkg::WK_IDLE && i_link_in_l2 && i_wake_request;
   endsequence

   sequence s_wake_hold;
      o_wake_assert ##1 (o_wake_assert || !$past(i_link_in_l2));
   endsequence

   a_pin_needs_short: assert property (!i_slot_limit_short |=> !o_power_limit_exceeded_pin)
      else $error("override pin asserted without slot limit shortfall");
   a_pin_ignore_sel: assert property ((gen_ff.spr_sel == bpoc_pkg::SPR_IGNORE) |=>
      !o_power_limit_exceeded_pin)
      else $error("override pin asserted with ignore selection");
   a_pin_both_sel: assert property (((gen_ff.spr_sel == bpoc_pkg::SPR_PIN) ||
      (gen_ff.spr_sel == bpoc_pkg::SPR_BOTH)) && i_slot_limit_short
      |=> o_power_limit_exceeded_pin)
      else $error("override pin missing while limit exceeded");
   a_clk_mask_stop: assert property ((gen_ff.spr_sel == bpoc_pkg::SPR_CLKSTOP) &&
      i_slot_limit_short && clk_mask_ff[0] |=> !o_sec_clk_en[0])
      else $error("masked clock kept running under override");
   a_clk_unmask_run: assert property ((gen_ff.spr_sel == bpoc_pkg::SPR_BOTH) &&
      !i_d3_state |=> (o_sec_clk_en | $past(clk_mask_ff | clk_dis_ff)) == '1)
      else $error("unmasked clock stopped under override");
   a_unsup_mem_rd: assert property (i_req_valid && i_slot_limit_short &&
      (gen_ff.spr_sel == bpoc_pkg::SPR_UNSUP) && (i_req_kind == bpoc_pkg::REQ_MEM_RD)
      |=> o_req_done && o_req_unsupported)
      else $error("memory read not answered unsupported");
   a_cfg_exempt: assert property (i_req_valid && (i_req_kind inside {bpoc_pkg::REQ_CFG0,
      bpoc_pkg::REQ_CFG1, bpoc_pkg::REQ_SET_SLOT_PWR}) |=> !o_req_unsupported)
      else $error("configuration request answered unsupported");
   a_spec_plain_on: assert property (i_req_valid && (i_req_kind == bpoc_pkg::REQ_MEM_RD) &&
      !gen_ff.spec_off && (gen_ff.spr_sel == bpoc_pkg::SPR_IGNORE) |=> o_req_prefetch)
      else $error("plain read not prefetched");
   a_spec_plain_off: assert property (i_req_valid && (i_req_kind == bpoc_pkg::REQ_MEM_RD) &&
      gen_ff.spec_off |=> !o_req_prefetch)
      else $error("plain read prefetched with speculation off");
   a_cap_copy: assert property (##1
      o_cap_shallow_idle_exit == $past(gen_ff.shallow) &&
      o_cap_deep_idle_exit == $past(gen_ff.deep))
      else $error("capability copy does not follow control field");
   a_vc_reads_zero: assert property (i_cfg.rd && cfg_hit(i_cfg.addr, bpoc_pkg::GEN_CTRL_OFS)
      |=> o_cfg_rvalid && !o_cfg_rdata[bpoc_pkg::VC_BIT])
      else $error("virtual channel enable read as one");
   a_d3_clk_stop: assert property (i_d3_state && gen_ff.d3_stop |=> o_sec_clk_en == '0)
      else $error("secondary clocks running in D3 with stop set");
   a_wake_sideband: assert property (s_wake_start |=> s_wake_hold)
      else $error("wake not signalled from L2");
   a_wake_no_beacon: assert property (s_wake_start ##0 !gen_ff.beacon |=> !o_beacon_assert)
      else $error("beacon used while disabled");
   a_sticky_clear: assert property ((i_link_reset || i_global_reset_pin) |=>
      gen_ff == bpoc_pkg::GEN_RESET)
      else $error("link or global reset did not clear control fields");
   a_reserved_sel: assert property ((gen_ff.spr_sel > bpoc_pkg::SPR_UNSUP) |=>
      !o_power_limit_exceeded_pin)
      else $error("reserved selection acted on slot limit");
endmodule

// *** test/bpoc_link_model.sv ***
// Upstream link model: enters L2 on command, leaves it once woken
`timescale 1ns/1ps
module bpoc_link_model #(
   parameter int RESP = 4
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Command and wake inputs
   input wire logic i_go_l2,
   input wire logic i_wake_assert,
   input wire logic i_beacon_assert,
   // Link state
   output logic o_link_in_l2,
   output logic o_saw_beacon
);
   int cnt;

   // Reference clock assumed kept running in L2, so secondary clocks may live on
   // Slow on purpose: a wake must be held for RESP cycles before the link leaves L2
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_link_in_l2 <= 1'b0;
         o_saw_beacon <= 1'b0;
         cnt <= 0;
      end else if (i_go_l2) begin
         o_link_in_l2 <= 1'b1;
         o_saw_beacon <= 1'b0;
         cnt <= 0;
      end else if (o_link_in_l2 && i_wake_assert) begin
         cnt <= cnt + 1;
         if (i_beacon_assert) begin
            o_saw_beacon <= 1'b1;
         end
         if (cnt == RESP - 1) begin
            o_link_in_l2 <= 1'b0;
         end
      end
   end
endmodule

// *** test/bridge_power_override_control_tb_top.sv ***
// Testbench: register access, override matrix, requests, D3 clocks, wake, clears
`timescale 1ns/1ps
module bridge_power_override_control_tb_top;
   localparam logic [7:0] GEN = bpoc_pkg::GEN_CTRL_OFS;
   localparam logic [7:0] CLK = bpoc_pkg::CLK_CTRL_OFS;
   localparam logic [6:0] MASK = 7'h55;
   localparam logic [6:0] DIS = 7'h02;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic link_rst = 1'b0;
   logic glob_rst = 1'b0;
   bpoc_pkg::bpoc_cfg_req_type cfg = '0;
   logic [31:0] rdata;
   logic rvalid, short_lim = 1'b0, d3 = 1'b0, req_valid = 1'b0;
   bpoc_pkg::bpoc_req_kind_type req_kind = bpoc_pkg::REQ_MEM_RD;
   logic done, unsup, pref, pin, wake, beacon, wake_req = 1'b0, go_l2 = 1'b0, in_l2, saw_bc;
   logic [6:0] clk_en;
   logic [2:0] cap_sh, cap_dp;
   logic eu;
   int errors = 0;
   int n_checks = 0;
   int sp, sh, s, k, i;

   // Free-running 40 MHz clock
   always #12.5 clk = ~clk;

   bpoc_top #(.N_CLK(7)) u_bpoc_top (.i_clk(clk), .i_rst(rst), .i_link_reset(link_rst),
      .i_global_reset_pin(glob_rst), .i_cfg(cfg), .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid),
      .i_slot_limit_short(short_lim), .i_d3_state(d3), .i_req_valid(req_valid),
      .i_req_kind(req_kind), .o_req_done(done), .o_req_unsupported(unsup),
      .o_req_prefetch(pref), .o_sec_clk_en(clk_en), .o_power_limit_exceeded_pin(pin),
      .i_link_in_l2(in_l2), .i_wake_request(wake_req), .o_wake_assert(wake),
      .o_beacon_assert(beacon), .o_cap_shallow_idle_exit(cap_sh),
      .o_cap_deep_idle_exit(cap_dp));

   bpoc_link_model #(.RESP(4)) u_bpoc_link_model (.i_clk(clk), .i_rst(rst), .i_go_l2(go_l2),
      .i_wake_assert(wake), .i_beacon_assert(beacon), .o_link_in_l2(in_l2),
      .o_saw_beacon(saw_bc));

   // Compare with case inequality so an unknown never matches
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Write strobe held for exactly one taking edge
   task automatic cfg_wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
      @(posedge clk);
      cfg <= '{1'b1, 1'b0, a, b, d};
      @(posedge clk);
      cfg <= '0;
   endtask

   // Read answer waited for under a bounded count
   task automatic cfg_rd(input logic [7:0] a, input logic [31:0] exp, input string name);
      int n;
      @(posedge clk);
      cfg <= '{1'b0, 1'b1, a, 4'hf, 32'h0};
      @(posedge clk);
      cfg <= '0;
      #1;
      for (n = 0; n < 4 && rvalid !== 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
      check({name, " valid"}, 32'(rvalid), 32'h1);
      check(name, rdata, exp);
   endtask

   // Request answered one cycle later
   task automatic req(input logic [2:0] kd, input logic e_un, input logic e_pf);
      @(posedge clk);
      req_valid <= 1'b1;
      req_kind <= bpoc_pkg::bpoc_req_kind_type'(kd);
      @(posedge clk);
      req_valid <= 1'b0;
      #1;
      check("done", 32'(done), 32'h1);
      check("unsupported", 32'(unsup), 32'(e_un));
      check("prefetch", 32'(pref), 32'(e_pf));
   endtask

   function automatic logic [31:0] gw(logic [2:0] sl, logic so, logic [2:0] shl, logic [2:0] dl,
      logic ds, logic bc);
      return {9'h0, sl, so, shl, dl, 1'b0, ds, bc, 10'h0};
   endfunction

   // Expected clock enables: disable bits always, mask under override, all in D3 stop
   function automatic logic [6:0] ce(logic [2:0] sl, logic lim, logic in_d3, logic ds);
      logic [6:0] off;
      off = DIS;
      if (lim && (sl == 3'h2 || sl == 3'h3)) off = off | MASK;
      if (in_d3 && ds) off = 7'h7f;
      return ~off;
   endfunction

   // Hang guard, a generous multiple of the expected run
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      $display("watchdog expired");
      results();
   end

   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      check("clk_en reset", 32'(clk_en), 32'h7f);
      check("pin reset", 32'(pin), 32'h0);
      cfg_rd(GEN, 32'h0, "gen reset");
      cfg_rd(CLK, 32'h0, "clk reset");
      cfg_rd(8'h40, 32'h0, "unmapped");
      $display("test reset done");
      // Read-only bit 12 and unstored bit 31 must not stick
      cfg_wr(GEN, 4'hf, gw(0, 1, 5, 3, 1, 1) | 32'h8000_1000);
      cfg_wr(CLK, 4'h3, {16'h0, 1'b0, MASK, 1'b0, DIS});
      cfg_rd(GEN, gw(0, 1, 5, 3, 1, 1), "gen");
      cfg_rd(CLK, {16'h0, 1'b0, MASK, 1'b0, DIS}, "clk ctrl");
      cfg_rd(bpoc_pkg::DEV_CAP_OFS, {20'h0, 3'h3, 3'h5, 6'h0}, "dev cap");
      check("cap shallow", 32'(cap_sh), 32'h5);
      check("cap deep", 32'(cap_dp), 32'h3);
      cfg_wr(GEN, 4'h2, 32'hffff_0000);
      cfg_rd(GEN, gw(0, 1, 5, 0, 0, 0), "gen byte1");
      $display("test fields done");
      // Every selection, limit short or not, every request kind
      for (sp = 0; sp < 2; sp++) begin
         for (sh = 0; sh < 2; sh++) begin
            for (s = 0; s < 8; s++) begin
               @(posedge clk);
               short_lim <= sh[0];
               cfg_wr(GEN, 4'h4, gw(s[2:0], sp[0], 0, 0, 0, 0));
               repeat (3) @(posedge clk);
               #1;
               check("pin", 32'(pin), 32'(sh[0] && (s == 1 || s == 3)));
               check("clk_en", 32'(clk_en), 32'(ce(s[2:0], sh[0], 0, 0)));
               for (k = 0; k < 8; k++) begin
                  eu = sh[0] && s == 4 && !(k inside {3, 4, 5});
                  req(k[2:0], eu, !eu && (k == 1 || k == 2 || (k == 0 && !sp[0])));
               end
            end
         end
      end
      $display("test override done");
      for (s = 0; s < 2; s++) begin
         cfg_wr(GEN, 4'h6, gw(0, 0, 0, 0, s[0], 0));
         @(posedge clk);
         d3 <= 1'b1;
         repeat (3) @(posedge clk);
         #1;
         check("clk_en d3", 32'(clk_en), 32'(ce(0, 1, 1, s[0])));
         @(posedge clk);
         d3 <= 1'b0;
      end
      $display("test d3 done");
      for (s = 0; s < 2; s++) begin
         cfg_wr(GEN, 4'h6, gw(0, 0, 0, 0, 0, s[0]));
         @(posedge clk);
         go_l2 <= 1'b1;
         @(posedge clk);
         go_l2 <= 1'b0;
         wake_req <= 1'b1;
         #1;
         for (i = 0; i < 10 && wake !== 1'b1; i++) begin
            @(posedge clk);
            #1;
         end
         check("wake", 32'(wake), 32'h1);
         check("beacon", 32'(beacon), 32'(s[0]));
         for (i = 0; i < 20 && in_l2 !== 1'b0; i++) begin
            @(posedge clk);
            #1;
         end
         check("beacon seen", 32'(saw_bc), 32'(s[0]));
         repeat (2) @(posedge clk);
         #1;
         check("wake released", 32'(wake), 32'h0);
         @(posedge clk);
         wake_req <= 1'b0;
      end
      $display("test wake done");
      for (s = 0; s < 2; s++) begin
         cfg_wr(GEN, 4'hf, gw(3, 1, 2, 2, 1, 1));
         cfg_wr(CLK, 4'h3, {16'h0, 1'b0, MASK, 1'b0, DIS});
         @(posedge clk);
         link_rst <= (s == 0);
         glob_rst <= (s == 1);
         @(posedge clk);
         link_rst <= 1'b0;
         glob_rst <= 1'b0;
         cfg_rd(GEN, 32'h0, "gen cleared");
         cfg_rd(CLK, 32'h0, "clk cleared");
      end
      $display("test clears done");
      results();
   end
endmodule
